// >>> qrf_pkg.sv
// Shared constants, types and code tables for the quad receive output block
package qrf_pkg;

  typedef enum logic [1:0] {QRF_LOW, QRF_MID, QRF_HIGH} qrf_level_type;

  localparam int QRF_NUM_CH = 4;
  localparam int QRF_CHAR_W = 10;
  localparam int QRF_BYTE_W = 8;
  localparam int QRF_ST_W = 3;
  localparam int QRF_FIFO_DEPTH = 4;
  localparam int QRF_SYNC_W = 25;

  // Field positions inside a raw character: abcdei high, fghj low
  localparam int QRF_SIX_LSB = 4;
  localparam int QRF_LOW_BITS = 2;

  // Positions of the static pins and the reference and link clocks inside the synchroniser vector
  localparam int QRF_POS_DEC = 0;
  localparam int QRF_POS_PAR = 2;
  localparam int QRF_POS_FCHAR = 4;
  localparam int QRF_POS_FMODE = 6;
  localparam int QRF_POS_RXMODE = 8;
  localparam int QRF_POS_TXMODE = 12;
  localparam int QRF_POS_SRC = 16;
  localparam int QRF_POS_RATE = 18;
  localparam int QRF_POS_REFRAME_ENABLE = 19;
  localparam int QRF_POS_REF = 20;
  localparam int QRF_POS_LINK = 21;

  // Encoded character status with the decoder in use
  localparam logic [2:0] QRF_ST_DATA = 3'h0;
  localparam logic [2:0] QRF_ST_SPECIAL = 3'h1;
  localparam logic [2:0] QRF_ST_INVALID = 3'h2;

  localparam logic [7:0] QRF_COMMA_NEG = 8'h3E;
  localparam logic [7:0] QRF_COMMA_POS = 8'hC1;
  localparam logic [9:0] QRF_K285_NEG = 10'h0FA;
  localparam logic [9:0] QRF_K285_POS = 10'h305;
  localparam logic [5:0] QRF_K28_NEG = 6'h0F;
  localparam logic [5:0] QRF_K28_POS = 6'h30;
  localparam logic [4:0] QRF_K28_LOW5 = 5'h1C;

  // Negative running disparity forms, index is the data value
  localparam logic [5:0] QRF_CODE6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] QRF_CODE4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  // Pin pair: bit 1 strapped high, bit 0 strapped low, neither means floating
  function automatic qrf_level_type qrf_resolve(input logic [1:0] pins);
    if (pins[1]) begin
      return QRF_HIGH;
    end else if (pins[0]) begin
      return QRF_LOW;
    end
    return QRF_MID;
  endfunction

endpackage

// >>> qrf_fifo.sv
// Small valid/ready FIFO holding framed characters ahead of the output register
`timescale 1ns/100ps
`default_nettype none
module qrf_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_push;
  logic do_pop;

  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end

  a_fifo_bounds: assert property (@(posedge clk_sys) disable iff (!arst_n)
    count <= FULL_COUNT) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// >>> qrf_rx_output_ctrl.sv
// Four-channel receive framing, decoding and parallel output stage
`timescale 1ns/100ps
`default_nettype none
module qrf_rx_output_ctrl
  import qrf_pkg::*;
#(
  parameter int FIFO_DEPTH = QRF_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic reference_clock,
  input wire logic [QRF_NUM_CH-1:0] rx_link_clock,
  input wire logic [QRF_NUM_CH*QRF_CHAR_W-1:0] rx_raw_char,
  input wire logic [1:0] decoder_mode_sel,
  input wire logic [1:0] parity_control_sel,
  input wire logic [1:0] framing_char_sel,
  input wire logic [1:0] framing_mode_sel,
  input wire logic [3:0] rx_operating_mode_sel,
  input wire logic [3:0] tx_operating_mode_sel,
  input wire logic [1:0] rx_clock_source_sel,
  input wire logic rx_clock_rate_sel,
  input wire logic reframe_enable,
  output logic [QRF_NUM_CH*QRF_BYTE_W-1:0] rx_char_bus,
  output logic [QRF_NUM_CH*QRF_ST_W-1:0] rx_char_status,
  output logic [QRF_NUM_CH-1:0] rx_odd_parity_out,
  output logic [QRF_NUM_CH-1:0] rx_odd_parity_oe,
  output logic [QRF_NUM_CH-1:0] rx_interface_clock,
  output logic [QRF_NUM_CH-1:0] rx_interface_clock_n,
  output logic [3:0] rx_mode_index,
  output logic [3:0] tx_mode_index
);

  // Decoder: data byte, K28 special or invalid (byte zero), status marks which
  function automatic logic [10:0] decode_char(input logic [9:0] raw);
    logic [5:0] six;
    logic [3:0] four;
    logic [4:0] low5;
    logic [2:0] high3;
    logic hit6;
    logic hit4;
    logic special;
    six = raw[9:QRF_SIX_LSB];
    // K28 positive form inverts fghj; undo it before the lookup
    four = (six == QRF_K28_POS) ? ~raw[QRF_SIX_LSB-1:0] : raw[QRF_SIX_LSB-1:0];
    low5 = '0;
    high3 = '0;
    hit6 = 1'b0;
    hit4 = 1'b0;
    special = (six == QRF_K28_NEG) || (six == QRF_K28_POS);
    // Exact match first; balanced codes alias under complement
    for (int i = 0; i < 32; i++) begin
      if (!hit6 && six == QRF_CODE6[i]) begin
        hit6 = 1'b1;
        low5 = 5'(i);
      end
    end
    for (int i = 0; i < 32; i++) begin
      if (!hit6 && six == ~QRF_CODE6[i]) begin
        hit6 = 1'b1;
        low5 = 5'(i);
      end
    end
    for (int j = 0; j < 8; j++) begin
      if (!hit4 && four == QRF_CODE4[j]) begin
        hit4 = 1'b1;
        high3 = 3'(j);
      end
    end
    for (int j = 0; j < 8; j++) begin
      if (!hit4 && four == ~QRF_CODE4[j]) begin
        hit4 = 1'b1;
        high3 = 3'(j);
      end
    end
    if (!hit4 && (four == 4'h7 || four == 4'h8)) begin
      hit4 = 1'b1;
      high3 = 3'h7;
    end
    if (special && hit4) begin
      return {QRF_ST_SPECIAL, high3, QRF_K28_LOW5};
    end else if (hit6 && hit4) begin
      return {QRF_ST_DATA, high3, low5};
    end
    return {QRF_ST_INVALID, 8'h00};
  endfunction

  // Every pin from outside passes two flops before use
  logic [QRF_SYNC_W-1:0] pin_meta;
  logic [QRF_SYNC_W-1:0] pin_sync;
  logic [QRF_NUM_CH*QRF_CHAR_W-1:0] raw_meta;
  logic [QRF_NUM_CH*QRF_CHAR_W-1:0] raw_sync;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      raw_meta <= '0;
      raw_sync <= '0;
    end else begin
      pin_meta <= {rx_link_clock, reference_clock, reframe_enable, rx_clock_rate_sel,
                   rx_clock_source_sel, tx_operating_mode_sel, rx_operating_mode_sel,
                   framing_mode_sel, framing_char_sel, parity_control_sel,
                   decoder_mode_sel};
      pin_sync <= pin_meta;
      raw_meta <= rx_raw_char;
      raw_sync <= raw_meta;
    end
  end

  qrf_level_type dec_lvl;
  qrf_level_type par_lvl;
  qrf_level_type fchar_lvl;
  qrf_level_type fmode_lvl;
  qrf_level_type src_lvl;
  qrf_level_type rx_hi_lvl;
  qrf_level_type rx_lo_lvl;
  qrf_level_type tx_hi_lvl;
  qrf_level_type tx_lo_lvl;
  logic rate_half;
  logic reframe_sync;
  logic ref_level;
  logic ref_prev;
  logic ref_rise;
  logic [QRF_NUM_CH-1:0] link_level;
  logic [QRF_NUM_CH-1:0] link_prev;
  logic [QRF_NUM_CH-1:0] link_rise;

  assign dec_lvl = qrf_resolve(pin_sync[QRF_POS_DEC +: 2]);
  assign par_lvl = qrf_resolve(pin_sync[QRF_POS_PAR +: 2]);
  assign fchar_lvl = qrf_resolve(pin_sync[QRF_POS_FCHAR +: 2]);
  assign fmode_lvl = qrf_resolve(pin_sync[QRF_POS_FMODE +: 2]);
  assign src_lvl = qrf_resolve(pin_sync[QRF_POS_SRC +: 2]);
  assign rx_lo_lvl = qrf_resolve(pin_sync[QRF_POS_RXMODE +: 2]);
  assign rx_hi_lvl = qrf_resolve(pin_sync[QRF_POS_RXMODE+2 +: 2]);
  assign tx_lo_lvl = qrf_resolve(pin_sync[QRF_POS_TXMODE +: 2]);
  assign tx_hi_lvl = qrf_resolve(pin_sync[QRF_POS_TXMODE+2 +: 2]);
  assign rate_half = pin_sync[QRF_POS_RATE];
  assign reframe_sync = pin_sync[QRF_POS_REFRAME_ENABLE];
  assign ref_level = pin_sync[QRF_POS_REF];
  assign link_level = pin_sync[QRF_POS_LINK +: QRF_NUM_CH];
  assign ref_rise = ref_level && !ref_prev;
  assign link_rise = link_level & ~link_prev;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_prev <= 1'b0;
      link_prev <= '0;
    end else begin
      ref_prev <= ref_level;
      link_prev <= link_level;
    end
  end

  // Nine modes each, index is three times the upper select plus the lower
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_mode_index <= '0;
      tx_mode_index <= '0;
    end else begin
      rx_mode_index <= 4'(4'(rx_hi_lvl) * 4'h3 + 4'(rx_lo_lvl));
      tx_mode_index <= 4'(4'(tx_hi_lvl) * 4'h3 + 4'(tx_lo_lvl));
    end
  end

  // Framing off with the test-only setting or framing mode low
  logic framer_allowed;
  assign framer_allowed = reframe_sync && fchar_lvl != QRF_LOW
                          && fmode_lvl != QRF_LOW;

  for (genvar ch = 0; ch < QRF_NUM_CH; ch++) begin : g_ch
    logic [QRF_CHAR_W-1:0] raw_now;
    logic [QRF_CHAR_W-1:0] prev_char;
    logic [2*QRF_CHAR_W-1:0] window;
    logic [3:0] offset;
    logic [3:0] next_offset;
    logic found;
    logic [QRF_CHAR_W-1:0] aligned;
    logic push_valid;
    logic push_ready;
    logic [QRF_CHAR_W-1:0] push_data;
    logic pop_valid;
    logic pop_due;
    logic [QRF_CHAR_W-1:0] pop_data;
    logic [10:0] decoded;
    logic [QRF_BYTE_W-1:0] next_bus;
    logic [QRF_ST_W-1:0] next_status;
    logic [QRF_BYTE_W-1:0] bus;
    logic [QRF_ST_W-1:0] status;
    logic parity;
    logic parity_oe;
    logic clk_true;
    logic clk_comp;
    logic pop_event;

    assign raw_now = raw_sync[ch*QRF_CHAR_W +: QRF_CHAR_W];
    assign window = {prev_char, raw_now};
    assign aligned = window[5'd19 - {1'b0, offset} -: QRF_CHAR_W];

    always_comb begin
      logic [QRF_CHAR_W-1:0] cand;
      logic match;
      cand = '0;
      match = 1'b0;
      next_offset = offset;
      found = 1'b0;
      for (int k = 0; k < QRF_CHAR_W; k++) begin
        cand = window[19-k -: QRF_CHAR_W];
        if (fchar_lvl == QRF_HIGH) begin
          match = (cand == QRF_K285_NEG) || (cand == QRF_K285_POS);
        end else begin
          match = (cand[9:2] == QRF_COMMA_NEG) || (cand[9:2] == QRF_COMMA_POS);
        end
        if (!found && match) begin
          found = 1'b1;
          next_offset = 4'(k);
        end
      end
    end

    // A character still waiting when the next arrives is overwritten
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        prev_char <= '0;
        offset <= '0;
        push_valid <= 1'b0;
        push_data <= '0;
      end else begin
        if (link_rise[ch]) begin
          prev_char <= raw_now;
          if (framer_allowed && found) begin
            offset <= next_offset;
          end
          push_valid <= 1'b1;
          push_data <= aligned;
        end else if (push_ready) begin
          push_valid <= 1'b0;
        end
      end
    end

    qrf_fifo #(
      .WIDTH(QRF_CHAR_W),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(pop_valid),
      .out_ready(pop_due),
      .out_data(pop_data)
    );

    // Data moves two cycles after the synchronised rise of the selected link or reference clock
    assign pop_event = (src_lvl == QRF_LOW) ? ref_rise : link_rise[ch];
    assign decoded = decode_char(pop_data);

    always_comb begin
      if (dec_lvl == QRF_LOW) begin
        next_bus = pop_data[QRF_CHAR_W-1:QRF_LOW_BITS];
        next_status = {(pop_data[9:2] == QRF_COMMA_NEG) || (pop_data[9:2] == QRF_COMMA_POS),
                       pop_data[QRF_LOW_BITS-1:0]};
      end else begin
        next_bus = decoded[7:0];
        next_status = decoded[10:8];
      end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        pop_due <= 1'b0;
        bus <= '0;
        status <= '0;
        parity <= 1'b1;
        parity_oe <= 1'b0;
      end else begin
        pop_due <= pop_event;
        parity_oe <= (par_lvl != QRF_LOW);
        if (pop_due && pop_valid) begin
          bus <= next_bus;
          status <= next_status;
          parity <= ~^next_bus;
        end
      end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        clk_true <= 1'b0;
        clk_comp <= 1'b1;
      end else if (src_lvl == QRF_LOW) begin
        // Only A and C carry the reference; B and D rest
        clk_true <= (ch == 0 || ch == 2) ? ref_level : 1'b0;
        clk_comp <= (ch == 0 || ch == 2) ? !ref_level : 1'b1;
      end else if (rate_half) begin
        if (link_rise[ch]) begin
          clk_true <= !clk_true;
          clk_comp <= clk_true;
        end
      end else begin
        clk_true <= link_level[ch];
        clk_comp <= !link_level[ch];
      end
    end

    assign rx_char_bus[ch*QRF_BYTE_W +: QRF_BYTE_W] = bus;
    assign rx_char_status[ch*QRF_ST_W +: QRF_ST_W] = status;
    assign rx_odd_parity_out[ch] = parity;
    assign rx_odd_parity_oe[ch] = parity_oe;
    assign rx_interface_clock[ch] = clk_true;
    assign rx_interface_clock_n[ch] = clk_comp;

    a_bus_after_edge: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $changed(bus) |-> $past(pop_event, 2)) else $error("bus moved without clock edge");
    a_status_with_bus: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $changed(status) |-> $past(pop_due && pop_valid)) else $error("status off data edge");
    a_parity_odd: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ^{bus, parity} == 1'b1) else $error("parity not odd");
    a_parity_released: assert property (@(posedge clk_sys) disable iff (!arst_n)
      par_lvl == QRF_LOW ##1 par_lvl == QRF_LOW |-> !parity_oe) else $error("parity driven");
    a_bypass_low_bits: assert property (@(posedge clk_sys) disable iff (!arst_n)
      pop_due && pop_valid && dec_lvl == QRF_LOW |=>
      status[1:0] == $past(pop_data[1:0]) && bus == $past(pop_data[9:2]))
      else $error("bypass fields wrong");
    a_half_rate_clock: assert property (@(posedge clk_sys) disable iff (!arst_n)
      src_lvl != QRF_LOW && rate_half && link_rise[ch] |=>
      clk_true != $past(clk_true) && clk_comp == !clk_true) else $error("half rate clock");
    a_full_rate_clock: assert property (@(posedge clk_sys) disable iff (!arst_n)
      src_lvl != QRF_LOW && !rate_half |=> clk_true == $past(link_level[ch]))
      else $error("full rate clock");
    a_offset_gated: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $changed(offset) |-> $past(framer_allowed && link_rise[ch])) else $error("offset moved");
    c_bypass_comma: cover property (@(posedge clk_sys) disable iff (!arst_n)
      dec_lvl == QRF_LOW && status[2]);
    c_special_char: cover property (@(posedge clk_sys) disable iff (!arst_n)
      dec_lvl != QRF_LOW && status == QRF_ST_SPECIAL);
    c_fifo_full: cover property (@(posedge clk_sys) disable iff (!arst_n)
      push_valid && !push_ready);
  end

  a_ref_follow: assert property (@(posedge clk_sys) disable iff (!arst_n)
    src_lvl == QRF_LOW |=> rx_interface_clock[0] == $past(ref_level)
    && rx_interface_clock[2] == $past(ref_level)) else $error("reference not followed");
  a_mode_range: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rx_mode_index < 4'h9 && tx_mode_index < 4'h9) else $error("mode index out of range");
endmodule
`default_nettype wire

// >>> qrf_link_source.sv
// Link-side model: recovered character clocks and raw characters
`timescale 1ns/100ps
`default_nettype none
module qrf_link_source (
  input wire logic clk_sys,
  output logic [3:0] rx_link_clock,
  output logic [39:0] rx_raw_char
);
  initial begin
    rx_link_clock = 4'h0;
    rx_raw_char = 40'h00_0000_0000;
  end

  // New char on the falling edge, four cycles of setup before the rise
  task automatic send(input logic [39:0] chars, input int periods);
    @(posedge clk_sys);
    #1;
    for (int i = 0; i < periods; i++) begin
      rx_link_clock = 4'h0;
      rx_raw_char = chars;
      repeat (4) @(posedge clk_sys);
      #1;
      rx_link_clock = 4'hf;
      repeat (4) @(posedge clk_sys);
      #1;
    end
    // Clock stands still between frames; the bus no longer holds the char
    rx_link_clock = 4'h0;
    rx_raw_char = ~chars;
  endtask
endmodule
`default_nettype wire

// >>> quad_receive_output_framing_ctrl_test.sv
// Testbench for the quad receive output and framing block
`timescale 1ns/100ps
`default_nettype none
module quad_receive_output_framing_ctrl_test;
  import qrf_pkg::*;
  typedef struct packed {
    logic [1:0] dec;
    logic [1:0] par;
    logic [9:0] raw;
    logic [7:0] bus;
    logic [2:0] st;
  } qrf_row_type;
  localparam qrf_row_type ROWS [7] = '{
    '{2'h1, 2'h0, 10'h0FA, 8'h3E, 3'h6},
    '{2'h1, 2'h2, 10'h305, 8'hC1, 3'h5},
    '{2'h1, 2'h1, 10'h2A7, 8'hA9, 3'h3},
    '{2'h0, 2'h0, 10'h319, 8'h23, 3'h0},
    '{2'h2, 2'h2, 10'h15A, 8'hAA, 3'h0},
    '{2'h0, 2'h1, 10'h000, 8'h00, 3'h2},
    '{2'h2, 2'h0, 10'h3FF, 8'h00, 3'h2}};
  localparam logic [9:0] SEQ [6] = '{10'h123, 10'h2B4, 10'h0C5, 10'h3D6, 10'h1E7, 10'h248};
  logic clk_sys, arst_n, reference_clock, rx_clock_rate_sel, reframe_enable;
  logic [1:0] decoder_mode_sel, parity_control_sel, framing_char_sel, framing_mode_sel;
  logic [1:0] rx_clock_source_sel;
  logic [3:0] rx_operating_mode_sel, tx_operating_mode_sel, rx_link_clock;
  logic [39:0] rx_raw_char;
  logic [31:0] rx_char_bus;
  logic [11:0] rx_char_status;
  logic [3:0] rx_odd_parity_out, rx_odd_parity_oe, rx_interface_clock, rx_interface_clock_n;
  logic [3:0] rx_mode_index, tx_mode_index, clk_q;
  logic ref_q;
  logic [9:0] r0, r1;
  logic [39:0] ss;
  int n_fail, comparisons, n_comp, ref_rises, k, d0;
  int rises [4];
  int a [4];

  qrf_rx_output_ctrl i_qrf_rx_output_ctrl (.clk_sys, .arst_n, .reference_clock, .rx_link_clock,
    .rx_raw_char, .decoder_mode_sel, .parity_control_sel, .framing_char_sel, .framing_mode_sel,
    .rx_operating_mode_sel, .tx_operating_mode_sel, .rx_clock_source_sel, .rx_clock_rate_sel,
    .reframe_enable, .rx_char_bus, .rx_char_status, .rx_odd_parity_out, .rx_odd_parity_oe,
    .rx_interface_clock, .rx_interface_clock_n, .rx_mode_index, .tx_mode_index);
  qrf_link_source i_qrf_link_source (.clk_sys, .rx_link_clock, .rx_raw_char);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Free-running reference, 350 ns, phase unrelated to the system clock
  initial begin
    reference_clock = 1'b0;
    #37;
    forever #175 reference_clock = ~reference_clock;
  end

  always @(posedge clk_sys) begin
    clk_q <= rx_interface_clock;
    ref_q <= reference_clock;
    if (reference_clock && !ref_q) ref_rises++;
    for (int c = 0; c < 4; c++) if (rx_interface_clock[c] && !clk_q[c]) rises[c]++;
    if (arst_n && rx_interface_clock_n !== ~rx_interface_clock) n_comp++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reset;
    chk(rx_char_bus, 32'h0000_0000);
    chk(32'(rx_char_status), 32'h0000_0000);
    chk(32'({rx_odd_parity_out, rx_odd_parity_oe}), 32'h0000_00F0);
    chk(32'({rx_interface_clock, rx_interface_clock_n}), 32'h0000_000F);
    chk(32'({rx_mode_index, tx_mode_index}), 32'h0000_0000);
  endtask

  task automatic test_done;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [1:0] enc(input int v);
    return (v == 0) ? 2'h1 : ((v == 1) ? 2'h0 : 2'h2);
  endfunction

  initial begin
    #4000000;
    n_fail++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 0, 1);
    test_done();
  end

  initial begin
    arst_n = 1'b0;
    decoder_mode_sel = 2'h0;
    parity_control_sel = 2'h0;
    framing_char_sel = 2'h0;
    framing_mode_sel = 2'h0;
    rx_operating_mode_sel = 4'h0;
    tx_operating_mode_sel = 4'h0;
    rx_clock_source_sel = 2'h0;
    rx_clock_rate_sel = 1'b0;
    reframe_enable = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1;
    chk_reset();
    arst_n = 1'b1;
    foreach (ROWS[r]) begin
      decoder_mode_sel = ROWS[r].dec;
      parity_control_sel = ROWS[r].par;
      i_qrf_link_source.send({4{ROWS[r].raw}}, 4);
      chk(rx_char_bus, {4{ROWS[r].bus}});
      chk(32'(rx_char_status), 32'({4{ROWS[r].st}}));
      chk(32'(rx_odd_parity_oe), (ROWS[r].par == 2'h1) ? 32'h0 : 32'hF);
      if (ROWS[r].par != 2'h1) chk(32'(rx_odd_parity_out), 32'({4{~^ROWS[r].bus}}));
    end
    $display("test rows done");
    for (int u = 0; u < 3; u++) begin
      for (int l = 0; l < 3; l++) begin
        rx_operating_mode_sel = {enc(u), enc(l)};
        tx_operating_mode_sel = {enc(l), enc(u)};
        repeat (4) @(posedge clk_sys);
        #1;
        chk(32'(rx_mode_index), 32'(3 * u + l));
        chk(32'(tx_mode_index), 32'(3 * l + u));
      end
    end
    $display("test modes done");
    // Alternating comma forms, shifted off the char boundary
    decoder_mode_sel = 2'h0;
    ss = {10'h0FA, 10'h305, 10'h0FA, 10'h305};
    reframe_enable = 1'b1;
    for (int t = 0; t < 4; t++) begin
      k = (t == 0) ? 3 : ((t == 1) ? 7 : 5);
      framing_char_sel = (t == 1) ? 2'h2 : 2'h0;
      reframe_enable = (t != 2);
      // Last pass: enabled, but framing mode strapped low freezes the framer
      framing_mode_sel = (t == 3) ? 2'h1 : 2'h0;
      r0 = ss[39-k -: 10];
      r1 = ss[29-k -: 10];
      for (int i = 0; i < 10; i++) begin
        i_qrf_link_source.send({4{r0}}, 1);
        i_qrf_link_source.send({4{r1}}, 1);
        if (i > 6 && t < 2) begin
          chk(rx_char_bus, 32'hBCBC_BCBC);
          chk(32'(rx_char_status), 32'({4{QRF_ST_SPECIAL}}));
        end
        if (i > 6 && t >= 2) chk(32'(rx_char_status[2:0] == QRF_ST_SPECIAL), 32'h0);
      end
    end
    reframe_enable = 1'b0;
    framing_mode_sel = 2'h0;
    $display("test framing done");
    for (int c = 0; c < 4; c++) a[c] = rises[c];
    i_qrf_link_source.send(40'h00_0000_0000, 4);
    for (int c = 0; c < 4; c++) chk(32'(rises[c] - a[c]), 32'h4);
    rx_clock_rate_sel = 1'b1;
    i_qrf_link_source.send(40'h00_0000_0000, 1);
    for (int c = 0; c < 4; c++) a[c] = rises[c];
    i_qrf_link_source.send(40'h00_0000_0000, 4);
    for (int c = 0; c < 4; c++) chk(32'(rises[c] - a[c]), 32'h2);
    rx_clock_source_sel = 2'h1;
    repeat (8) @(posedge clk_sys);
    #1;
    for (int c = 0; c < 4; c++) a[c] = rises[c];
    d0 = ref_rises;
    repeat (70) @(posedge clk_sys);
    #1;
    d0 = ref_rises - d0;
    chk(32'(rises[0] - a[0]), 32'(rises[2] - a[2]));
    chk(32'((rises[0] - a[0] >= d0 - 1) && (rises[0] - a[0] <= d0 + 1)), 32'h1);
    chk(32'(rises[1] + rises[3] - a[1] - a[3]), 32'h0);
    chk(32'(n_comp), 32'h0);
    rx_clock_source_sel = 2'h0;
    $display("test clocks done");
    arst_n = 1'b0;
    #1;
    chk_reset();
    decoder_mode_sel = 2'h1;
    repeat (3) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    $display("test reset done");
    // Framer at offset zero plus the FIFO stage: bus runs two characters behind
    for (int i = 0; i < 6; i++) begin
      i_qrf_link_source.send({4{SEQ[i]}}, 1);
      if (i > 1) begin
        chk(rx_char_bus, {4{SEQ[i-2][9:2]}});
        chk(32'(rx_char_status), 32'({4{1'b0, SEQ[i-2][1:0]}}));
      end
    end
    repeat (20) @(posedge clk_sys);
    #1;
    chk(rx_char_bus, {4{SEQ[3][9:2]}});
    $display("test fifo done");
    test_done();
  end
endmodule
`default_nettype wire
